// File: hw/acr_pkg.sv
/*
  Package for the converter output and clock configuration register bank:
  offsets, field positions, reset values, field carriers and modes.
  Assumes the serial port front end presents one decoded byte access per cycle.
*/
package acr_pkg;
  localparam logic [7:0] ACR_SELFTEST_CONTROL = 8'h0e;
  localparam logic [7:0] ACR_INPUT_SERVO_CONTROL = 8'h0f;
  localparam logic [7:0] ACR_OFFSET_TRIM = 8'h10;
  localparam logic [7:0] ACR_OUTPUT_FORMAT_CONTROL = 8'h14;
  localparam logic [7:0] ACR_CLOCK_PHASE_CONTROL = 8'h16;
  localparam logic [7:0] ACR_OUTPUT_CLOCK_DELAY = 8'h17;
  localparam logic [7:0] ACR_REFERENCE_SPAN_SELECT = 8'h18;
  localparam logic [7:0] ACR_SELFTEST_SIGNATURE_LOW = 8'h24;
  localparam logic [7:0] ACR_SELFTEST_SIGNATURE_HIGH = 8'h25;

  localparam logic [7:0] ACR_SELFTEST_CONTROL_RST = 8'h04;
  localparam logic [7:0] ACR_INPUT_SERVO_CONTROL_RST = 8'h00;
  localparam logic [7:0] ACR_OFFSET_TRIM_RST = 8'h00;
  localparam logic [7:0] ACR_OUTPUT_FORMAT_CONTROL_RST = 8'h00;
  localparam logic [7:0] ACR_CLOCK_PHASE_CONTROL_RST = 8'h00;
  localparam logic [7:0] ACR_OUTPUT_CLOCK_DELAY_RST = 8'h00;
  localparam logic [7:0] ACR_REFERENCE_SPAN_SELECT_RST = 8'hc0;

  // Writable bit masks; everything else reads zero
  localparam logic [7:0] ACR_SELFTEST_CONTROL_MASK = 8'h05;
  localparam logic [7:0] ACR_INPUT_SERVO_CONTROL_MASK = 8'h01;
  localparam logic [7:0] ACR_OFFSET_TRIM_MASK = 8'hff;
  localparam logic [7:0] ACR_OUTPUT_FORMAT_CONTROL_MASK = 8'hf7;
  localparam logic [7:0] ACR_CLOCK_PHASE_CONTROL_MASK = 8'h87;
  localparam logic [7:0] ACR_OUTPUT_CLOCK_DELAY_MASK = 8'h1f;
  localparam logic [7:0] ACR_REFERENCE_SPAN_SELECT_MASK = 8'hc0;

  localparam int ACR_SELFTEST_EN_BIT = 0;
  localparam int ACR_SELFTEST_RESTART_BIT = 2;
  localparam int ACR_OUT_INVERT_BIT = 2;
  localparam int ACR_OUT_DISABLE_BIT = 4;
  localparam int ACR_OUT_INTERLEAVE_BIT = 5;
  localparam int ACR_OUT_LVDS_BIT = 6;
  localparam int ACR_OUT_REDUCED_SWING_BIT = 7;
  localparam int ACR_CLK_INVERT_BIT = 7;

  localparam int ACR_SAMPLE_W = 16;
  localparam int ACR_CLOCK_DELAY_FULL_PS = 2500;
  localparam int ACR_CLOCK_DELAY_STEPS = 31;
  localparam logic [15:0] ACR_SIGNATURE_SEED = 16'h0000;
  localparam logic [15:0] ACR_SIGNATURE_POLY = 16'h8005;

  typedef enum logic [1:0]
  {
    ACR_FMT_OFFSET_BINARY = 2'b00,
    ACR_FMT_TWOS_COMPLEMENT = 2'b01,
    ACR_FMT_GRAY = 2'b10
  } acr_format_e;

  typedef struct packed
  {
    logic write_en;
    logic read_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acr_access_s;

  typedef struct packed
  {
    logic reduced_swing;
    logic lvds;
    logic interleave;
    logic output_disable;
    logic invert;
    logic [1:0] format;
  } acr_output_cfg_s;
endpackage

// File: hw/acr_clock_divider.sv
/*
  Input clock divider with phase delay, run as a clock enable generator.
  Assumes clock is the input clock and the enable freezes all counting.
*/
`timescale 1ns/1ps
module acr_clock_divider
  import acr_pkg::*;
(
  input wire logic clock, // Input clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic enable, // Clock enable
  input wire logic [2:0] ratio, // Divide ratio minus one
  input wire logic [2:0] phase, // Delay in input clock cycles
  input wire logic restart, // Reload the phase delay
  output logic tick // One cycle per divided period
);
  logic [2:0] delay_count;
  logic [2:0] div_count;
  logic [2:0] next_div_count;

  always_comb
  begin
    next_div_count = (div_count >= ratio) ? 3'h0 : 3'(div_count + 3'h1);
  end

  // The phase delay holds off the divider for the programmed number of cycles
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      delay_count <= 3'h0;
      div_count <= 3'h0;
      tick <= 1'b0;
    end
    else if (enable)
    begin
      // Reload waits for the enable too, so a frozen block keeps its count
      if (restart)
      begin
        delay_count <= phase; // see R3
        div_count <= 3'h0;
        tick <= 1'b0;
      end
      else if (delay_count != 3'h0)
      begin
        delay_count <= 3'(delay_count - 3'h1); // see R3
        tick <= 1'b0;
      end
      else
      begin
        div_count <= next_div_count; // see R5
        tick <= (div_count == 3'h0);
      end
    end
  end
endmodule // acr_clock_divider

// File: hw/acr_config_regs.sv
/*
  Output and clock configuration register bank of a dual channel converter,
  with offset trim, output coding and a self-test signature.
  Assumes the serial port front end decodes accesses and that channel gating
  and transfer commit are done upstream, so write_en is already committed.
*/
`timescale 1ns/1ps
//
// Behaviour
// R1: Add the signed trim, in output LSBs from +127 to -128, to each result.
// R2: Trim byte is two's complement; reset zero means no correction.
// R3: Divider input is delayed by the three-bit phase count in input cycles.
// R4: Output data clock delay is 2500 ps times code divided by 31.
// R5: Input clock is divided by one plus the three-bit ratio.
// R6: Unused bits read zero, writes to them ignored; signature is read-only.
module acr_config_regs
  import acr_pkg::*;
(
  input wire logic clock, // Sample clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic enable, // Clock enable
  input acr_pkg::acr_access_s access, // Decoded register access
  input wire logic write_channel_a, // Committed write targets channel A
  input wire logic write_channel_b, // Committed write targets channel B
  input wire logic read_channel_b, // Local reads return channel B
  input wire logic [2:0] divide_ratio, // Divide ratio from the global clock register
  input wire logic sample_valid, // Conversion results valid
  input wire logic [15:0] sample_a, // Raw result, channel A, offset binary
  input wire logic [15:0] sample_b, // Raw result, channel B, offset binary
  input wire logic output_disable_pin, // External output disable, high disables
  output logic [7:0] rdata, // Read data
  output logic rvalid, // Read data valid
  output logic [15:0] data_a, // Coded output, channel A
  output logic [15:0] data_b, // Coded output, channel B
  output logic data_valid, // Output data valid
  output logic data_oe, // Output drivers enabled
  output logic servo_enable, // Common-mode servo enable
  output logic [1:0] reference_span, // Reference span code
  output logic output_data_clock_invert, // Invert output data clock
  output logic [4:0] output_data_clock_delay, // Delay code, step 2500/31 ps
  output logic [11:0] output_data_clock_delay_ps, // Delay in ps
  output logic lvds_mode, // Output type LVDS
  output logic reduced_swing, // Reduced swing LVDS
  output logic interleave, // CMOS output interleave
  output logic divider_tick // Divided sample enable
);
  localparam int NCH = 2;

  logic [7:0] selftest_control;
  logic [7:0] input_servo_control;
  logic [7:0] offset_trim [NCH];
  logic [7:0] output_format_control [NCH];
  logic [7:0] clock_phase_control;
  logic [7:0] output_clock_delay;
  logic [7:0] reference_span_select;
  logic [15:0] signature [NCH];
  logic [NCH-1:0] wr_ch;
  logic restart_divider;
  logic [7:0] next_rdata;
  logic [15:0] coded [NCH];
  logic div_tick;

  assign wr_ch = {write_channel_b, write_channel_a};

  function automatic logic hit(input acr_access_s a, input logic [7:0] addr);
    hit = a.write_en && (a.addr == addr);
  endfunction

  function automatic logic [7:0] masked(input logic [7:0] v, input logic [7:0] m);
    masked = v & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Global registers
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      selftest_control <= ACR_SELFTEST_CONTROL_RST;
      input_servo_control <= ACR_INPUT_SERVO_CONTROL_RST;
      clock_phase_control <= ACR_CLOCK_PHASE_CONTROL_RST;
      output_clock_delay <= ACR_OUTPUT_CLOCK_DELAY_RST;
      reference_span_select <= ACR_REFERENCE_SPAN_SELECT_RST;
    end
    else if (enable)
    begin
      if (hit(access, ACR_SELFTEST_CONTROL))
        selftest_control <= masked(access.wdata, ACR_SELFTEST_CONTROL_MASK); // see R6
      else
        selftest_control[ACR_SELFTEST_RESTART_BIT] <= 1'b0;
      if (hit(access, ACR_INPUT_SERVO_CONTROL))
        input_servo_control <= masked(access.wdata, ACR_INPUT_SERVO_CONTROL_MASK); // see R6
      if (hit(access, ACR_CLOCK_PHASE_CONTROL))
        clock_phase_control <= masked(access.wdata, ACR_CLOCK_PHASE_CONTROL_MASK); // see R6
      if (hit(access, ACR_OUTPUT_CLOCK_DELAY))
        output_clock_delay <= masked(access.wdata, ACR_OUTPUT_CLOCK_DELAY_MASK); // see R6
      if (hit(access, ACR_REFERENCE_SPAN_SELECT))
        reference_span_select <= masked(access.wdata, ACR_REFERENCE_SPAN_SELECT_MASK); // see R6
    end
  end

  // A write to the phase register restarts the divider one cycle later, once the new phase is held
  always_ff @(posedge clock)
  begin
    if (!reset_n)
      restart_divider <= 1'b0;
    else if (enable)
      restart_divider <= hit(access, ACR_CLOCK_PHASE_CONTROL);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per channel registers, coding and self-test signature
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    logic [15:0] raw;
    logic [16:0] sum;
    logic [15:0] trimmed;
    logic [15:0] shaped;
    acr_output_cfg_s cfg;

    assign raw = (c == 0) ? sample_a : sample_b;
    // Bit 3 is open, so the carrier skips it
    assign cfg = {output_format_control[c][7:4], output_format_control[c][2:0]};

    always_comb
    begin
      // Sign-extended trim added, then clamped to the code range
      sum = {1'b0, raw} + {{9{offset_trim[c][7]}}, offset_trim[c]}; // see R1, R2
      if (offset_trim[c][7] && sum[16])
        trimmed = 16'h0000;
      else if (!offset_trim[c][7] && sum[16])
        trimmed = 16'hffff;
      else
        trimmed = sum[15:0];
      shaped = cfg.invert ? ~trimmed : trimmed;
      case (cfg.format)
        ACR_FMT_TWOS_COMPLEMENT: coded[c] = {~shaped[15], shaped[14:0]};
        ACR_FMT_GRAY: coded[c] = shaped ^ {1'b0, shaped[15:1]};
        default: coded[c] = shaped;
      endcase
    end

    always_ff @(posedge clock)
    begin
      if (!reset_n)
      begin
        offset_trim[c] <= ACR_OFFSET_TRIM_RST; // see R2
        output_format_control[c] <= ACR_OUTPUT_FORMAT_CONTROL_RST;
      end
      else if (enable && wr_ch[c])
      begin
        if (hit(access, ACR_OFFSET_TRIM))
          offset_trim[c] <= masked(access.wdata, ACR_OFFSET_TRIM_MASK);
        if (hit(access, ACR_OUTPUT_FORMAT_CONTROL))
          output_format_control[c] <= masked(access.wdata, ACR_OUTPUT_FORMAT_CONTROL_MASK); // see R6
      end
    end

    // Signature is a CRC over coded outputs while self-test runs
    always_ff @(posedge clock)
    begin
      if (!reset_n)
        signature[c] <= ACR_SIGNATURE_SEED;
      else if (enable && selftest_control[ACR_SELFTEST_RESTART_BIT])
        signature[c] <= ACR_SIGNATURE_SEED;
      else if (enable && selftest_control[ACR_SELFTEST_EN_BIT] && sample_valid && div_tick)
        signature[c] <= ({signature[c][14:0], 1'b0} ^ (signature[c][15] ? ACR_SIGNATURE_POLY : 16'h0000))
          ^ coded[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider
  acr_clock_divider u_divider
  (
    .clock(clock),
    .reset_n(reset_n),
    .enable(enable),
    .ratio(divide_ratio), // see R5
    .phase(clock_phase_control[2:0]), // see R3
    .restart(restart_divider),
    .tick(div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path; signatures have no write path at all
  always_comb
  begin
    case (access.addr)
      ACR_SELFTEST_CONTROL: next_rdata = selftest_control;
      ACR_INPUT_SERVO_CONTROL: next_rdata = input_servo_control;
      ACR_OFFSET_TRIM: next_rdata = offset_trim[read_channel_b];
      ACR_OUTPUT_FORMAT_CONTROL: next_rdata = output_format_control[read_channel_b];
      ACR_CLOCK_PHASE_CONTROL: next_rdata = clock_phase_control;
      ACR_OUTPUT_CLOCK_DELAY: next_rdata = output_clock_delay;
      ACR_REFERENCE_SPAN_SELECT: next_rdata = reference_span_select;
      ACR_SELFTEST_SIGNATURE_LOW: next_rdata = signature[read_channel_b][7:0]; // see R6
      ACR_SELFTEST_SIGNATURE_HIGH: next_rdata = signature[read_channel_b][15:8]; // see R6
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end
    else if (enable)
    begin
      rdata <= access.read_en ? next_rdata : 8'h00;
      rvalid <= access.read_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      data_a <= 16'h0000;
      data_b <= 16'h0000;
      data_valid <= 1'b0;
      data_oe <= 1'b0;
      servo_enable <= 1'b0;
      reference_span <= 2'b11;
      output_data_clock_invert <= 1'b0;
      output_data_clock_delay <= 5'h00;
      output_data_clock_delay_ps <= 12'h000;
      lvds_mode <= 1'b0;
      reduced_swing <= 1'b0;
      interleave <= 1'b0;
      divider_tick <= 1'b0;
    end
    else if (enable)
    begin
      data_a <= coded[0];
      data_b <= coded[1];
      data_valid <= sample_valid && div_tick;
      data_oe <= !output_disable_pin && !output_format_control[0][ACR_OUT_DISABLE_BIT];
      servo_enable <= input_servo_control[0];
      reference_span <= reference_span_select[7:6];
      output_data_clock_invert <= clock_phase_control[ACR_CLK_INVERT_BIT];
      output_data_clock_delay <= output_clock_delay[4:0]; // see R4
      output_data_clock_delay_ps <= 12'((ACR_CLOCK_DELAY_FULL_PS * 32'(output_clock_delay[4:0]))
        / ACR_CLOCK_DELAY_STEPS); // see R4
      lvds_mode <= output_format_control[0][ACR_OUT_LVDS_BIT];
      reduced_swing <= output_format_control[0][ACR_OUT_REDUCED_SWING_BIT];
      interleave <= output_format_control[0][ACR_OUT_INTERLEAVE_BIT];
      divider_tick <= div_tick;
    end
  end
endmodule // acr_config_regs

// File: verif/acr_host_model.sv
/*
  Host side model: issues decoded register accesses, one at a time.
  Assumes the block takes an access on the rising edge; drives on the falling edge.
*/
`timescale 1ns/1ps
module acr_host_model
  import acr_pkg::*;
(
  input wire logic clock, // Sample clock
  input wire logic [7:0] rdata, // Read data
  input wire logic rvalid, // Read data valid
  output acr_pkg::acr_access_s access // Access toward the block
);
  initial access = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    access = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    access = '0;
  endtask
  // Read data is taken half a cycle after the access edge, on the next falling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge clock);
    access = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    q = rdata;
    v = rvalid;
    access = '0;
  endtask
endmodule // acr_host_model

// File: verif/acr_config_regs_checker.sv
/*
  Port checker for the configuration register bank.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module acr_config_regs_checker
  import acr_pkg::*;
(
  input wire logic clock, // Sample clock
  input wire logic reset_n, // Reset, active low
  input wire logic enable, // Clock enable
  input acr_pkg::acr_access_s access, // Register access
  input wire logic sample_valid, // Results valid
  input wire logic [7:0] rdata, // Read data
  input wire logic rvalid, // Read valid
  input wire logic data_valid, // Output valid
  input wire logic servo_enable, // Servo enable
  input wire logic [1:0] reference_span, // Span code
  input wire logic [4:0] output_data_clock_delay, // Delay code
  input wire logic [11:0] output_data_clock_delay_ps // Delay in ps
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic rd = enable && access.read_en;
  wire logic wr = enable && access.write_en;
  a_read_answer: assert property (rd |=> rvalid) else $error("read gave no valid");
  a_read_quiet: assert property (enable && !access.read_en |=> !rvalid) else $error("stray read valid");
  a_unmapped_zero: assert property (rd && access.addr > 8'h25 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_delay_ps: assert property (output_data_clock_delay_ps ==
    12'((ACR_CLOCK_DELAY_FULL_PS * output_data_clock_delay) / ACR_CLOCK_DELAY_STEPS)) else $error("delay ps wrong");
  a_delay_write: assert property (wr && access.addr == 8'h17 |=> ##1
    output_data_clock_delay == $past(access.wdata[4:0], 2)) else $error("delay code wrong");
  a_servo_write: assert property (wr && access.addr == 8'h0f |=> ##1
    servo_enable == $past(access.wdata[0], 2)) else $error("servo enable wrong");
  a_span_write: assert property (wr && access.addr == 8'h18 |=> ##1
    reference_span == $past(access.wdata[7:6], 2)) else $error("span wrong");
  a_span_reset: assert property ($rose(reset_n) |-> reference_span == 2'b11) else $error("span reset");
  a_valid_cause: assert property (data_valid |-> $past(sample_valid)) else $error("valid without sample");
endmodule // acr_config_regs_checker

bind acr_config_regs acr_config_regs_checker chk (.clock(clock), .reset_n(reset_n), .enable(enable),
  .access(access), .sample_valid(sample_valid), .rdata(rdata), .rvalid(rvalid), .data_valid(data_valid),
  .servo_enable(servo_enable), .reference_span(reference_span),
  .output_data_clock_delay(output_data_clock_delay), .output_data_clock_delay_ps(output_data_clock_delay_ps));

// File: verif/adc_output_and_clock_config_regs_test.sv
/*
  Self-checking bench for the configuration register bank.
  Assumes the host model drives accesses and the checker is bound to uut.
*/
`timescale 1ns/1ps
module adc_output_and_clock_config_regs_test;
  import acr_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic enable = 1'b1;
  logic [2:0] divide_ratio = 3'h0;
  logic sample_valid = 1'b0;
  logic [15:0] sample_a = 16'h0000;
  logic pin = 1'b0;
  acr_access_s access;
  logic [7:0] rdata;
  logic rvalid, data_valid, data_oe, tick;
  logic [15:0] data_a;
  logic [4:0] dly;
  logic [11:0] dly_ps;
  logic wr_a = 1'b1;
  logic wr_b = 1'b0;
  logic rd_b = 1'b0;
  logic [15:0] sample_b = 16'h0000;
  logic [15:0] data_b;
  logic clk_inv, lvds, swing, ilv;
  int failures = 0;
  int checks_done = 0;
  // Restart bit of 0x0e clears itself just after reset
  localparam logic [7:0] ADDRS [8] = '{8'h0e, 8'h0f, 8'h10, 8'h14, 8'h16, 8'h17, 8'h18, 8'h24};
  localparam logic [7:0] RSTS [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00};
  localparam logic [7:0] MASKS [8] = '{8'h01, 8'h01, 8'hff, 8'hf7, 8'h87, 8'h1f, 8'hc0, 8'h00};
  always #5 clock = ~clock;
  acr_host_model host (.clock(clock), .rdata(rdata), .rvalid(rvalid), .access(access));
  acr_config_regs uut (.clock(clock), .reset_n(reset_n), .enable(enable), .access(access),
    .write_channel_a(wr_a), .write_channel_b(wr_b), .read_channel_b(rd_b), .divide_ratio(divide_ratio),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b), .output_disable_pin(pin),
    .rdata(rdata), .rvalid(rvalid), .data_a(data_a), .data_b(data_b), .data_valid(data_valid), .data_oe(data_oe),
    .servo_enable(), .reference_span(), .output_data_clock_invert(clk_inv), .output_data_clock_delay(dly),
    .output_data_clock_delay_ps(dly_ps), .lvds_mode(lvds), .reduced_swing(swing), .interleave(ilv),
    .divider_tick(tick));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    logic v;
    host.rd(a, q, v);
    chk({15'h0, v}, 16'h0001, "rvalid");
    chk({8'h00, q}, {8'h00, exp}, "rdata");
  endtask
  task automatic test_regs();
    for (int i = 0; i < 8; i++)
      rd_chk(ADDRS[i], RSTS[i]);
    for (int i = 0; i < 8; i++)
    begin
      host.wr(ADDRS[i], 8'hff);
      rd_chk(ADDRS[i], MASKS[i]);
      host.wr(ADDRS[i], 8'h00);
    end
    host.wr(8'h11, 8'h5a);
    rd_chk(8'h11, 8'h00);
  endtask
  task automatic test_delay();
    for (int c = 0; c < 32; c++)
    begin
      host.wr(8'h17, 8'(c));
      @(negedge clock);
      chk(16'(dly), 16'(c), "delay code");
      chk(16'(dly_ps), 16'(2500 * c / 31), "delay ps");
    end
    // Clock enable low must freeze the register against a write
    enable = 1'b0;
    host.wr(8'h17, 8'h05);
    enable = 1'b1;
    rd_chk(8'h17, 8'h1f);
  endtask
  // Result saturates at both ends of the 16-bit range
  task automatic trim_case(input logic [15:0] s, input int t);
    int e;
    e = int'(s) + t;
    if (e > 65535) e = 65535;
    if (e < 0) e = 0;
    host.wr(8'h10, 8'(t));
    sample_a = s;
    repeat (4) @(negedge clock);
    chk({15'h0, data_valid}, 16'h0001, "valid");
    chk(data_a, 16'(e), "trimmed result");
  endtask
  task automatic test_ratio();
    int n;
    for (int r = 0; r < 8; r++)
    begin
      n = 0;
      divide_ratio = 3'(r);
      repeat (16) @(negedge clock);
      repeat (8 * (r + 1))
      begin
        @(negedge clock);
        n += int'(tick === 1'b1);
      end
      chk(16'(n), 16'h0008, "ticks per window");
    end
    divide_ratio = 3'h0;
  endtask
  // Ticks in a fixed window after reload drop by the phase count
  task automatic test_phase();
    int n, n0, p;
    for (int k = 0; k < 3; k++)
    begin
      p = (k == 0) ? 0 : (k == 1) ? 5 : 7;
      n = 0;
      host.wr(8'h16, 8'(p));
      repeat (16)
      begin
        @(negedge clock);
        n += int'(tick === 1'b1);
      end
      if (k == 0) n0 = n;
      chk(16'(n0 - n), 16'(p), "phase delay");
    end
  endtask
  task automatic test_oe();
    pin = 1'b1;
    repeat (2) @(negedge clock);
    chk({15'h0, data_oe}, 16'h0000, "oe pin");
    pin = 1'b0;
    repeat (2) @(negedge clock);
    chk({15'h0, data_oe}, 16'h0001, "oe on");
  endtask
  task automatic test_sig();
    sample_valid = 1'b0;
    sample_a = 16'h1234;
    host.wr(8'h0e, 8'h05);
    @(negedge clock);
    sample_valid = 1'b1;
    repeat (2) @(negedge clock);
    sample_valid = 1'b0;
    // Two updates from seed zero over a steady 0x1234 give 0x365c
    rd_chk(8'h24, 8'h5c);
    rd_chk(8'h25, 8'h36);
    host.wr(8'h24, 8'hff);
    rd_chk(8'h24, 8'h5c);
    host.wr(8'h0e, 8'h04);
    rd_chk(8'h24, 8'h00);
  endtask
  task automatic test_outputs();
    sample_a = 16'hc3a5;
    host.wr(8'h14, 8'h01);
    @(negedge clock);
    chk(data_a, 16'h43a5, "twos complement");
    host.wr(8'h14, 8'h02);
    @(negedge clock);
    chk(data_a, 16'ha277, "gray code");
    host.wr(8'h14, 8'h04);
    @(negedge clock);
    chk(data_a, 16'h3c5a, "inverted");
    host.wr(8'h14, 8'hf3);
    @(negedge clock);
    chk(data_a, 16'hc3a5, "offset binary");
    chk({13'h0, lvds, swing, ilv}, 16'h0007, "output type");
    chk({15'h0, data_oe}, 16'h0000, "oe bit");
    host.wr(8'h14, 8'h00);
    host.wr(8'h16, 8'h80);
    @(negedge clock);
    chk({13'h0, lvds, swing, ilv}, 16'h0000, "output type off");
    chk({15'h0, clk_inv}, 16'h0001, "clock invert");
    host.wr(8'h16, 8'h00);
  endtask
  // Local registers follow the channel gates on write and read
  task automatic test_channel_b();
    wr_a = 1'b0;
    wr_b = 1'b1;
    sample_b = 16'h1000;
    host.wr(8'h10, 8'hfb);
    @(negedge clock);
    chk(data_b, 16'h0ffb, "channel b trim");
    chk(data_a, 16'hc3a5, "channel a untouched");
    rd_b = 1'b1;
    rd_chk(8'h10, 8'hfb);
    rd_b = 1'b0;
    rd_chk(8'h10, 8'h00);
    wr_a = 1'b1;
    wr_b = 1'b0;
  endtask
  task automatic final_report();
    $display("checks done %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    test_regs();
    test_delay();
    sample_valid = 1'b1;
    trim_case(16'h8000, 127);
    trim_case(16'h8000, -128);
    trim_case(16'hffff, 127);
    trim_case(16'h0000, -128);
    trim_case(16'h1234, 0);
    test_ratio();
    test_phase();
    test_oe();
    test_sig();
    test_outputs();
    test_channel_b();
    final_report();
  end
  // Whole run needs well under 2000 cycles
  initial
  begin
    #100000;
    failures++;
    final_report();
  end
endmodule // adc_output_and_clock_config_regs_test
